// File: inc/pms_defs.vh
// Purpose: constants for the management serial slave and its control regs
// Assumes: management clock sampled by core_clk, data sampled on its rise
// Notes: register offsets are management register addresses
// Function
// - Frame is 32 ones preamble, start 01, opcode, address 00AAA, register.
// - Read turnaround Z then 0, then 16 data bits; write uses 10.
// - Answer own address 0..7 and broadcast address 0 by default.
// - Broadcast off by strap at reset or control bit 9 of 16h.
// - Own management address 0..7 comes from three strap inputs.
// - Registers are 16 bits; 0..8 standard, higher ones extended.
// - Interrupt enables in 1Bh bits 15..8 gate each condition onto output.
// - Status bits 7..0 of 1Bh record conditions; reading 1Bh clears them.
// - Bit 9 of 1Fh selects interrupt polarity, active low by default.
// - Automatic crossover on by default; 1 in 1Fh bit 13 disables.
// - With crossover off, 1Fh bit 14 forces straight or crossed pairs.
// - Local loopback returns MAC transmit frames to MAC receive path.
// - 1Fh bit 3 set disables line transmitter, clear re-enables it.
// - 1Fh bit 2 enables remote loopback, valid only at 100 full duplex.
// - Remote loopback sends line frames back to the line partner.
// - 1Dh bit 15 starts diagnostic, reads 1 while running, self-clears.
// - Result in 1Dh bits 14..13: normal, open, short, failed.
// - Report 11 without test when line partner cannot be silenced.
// - Nine-bit fault distance count in 1Dh bits 8..0, times 0.38.
`ifndef PMS_DEFS_VH
`define PMS_DEFS_VH
`define PMS_REG_BCTL 5'h00
`define PMS_REG_OMO 5'h16
`define PMS_REG_ICS 5'h1B
`define PMS_REG_CDC 5'h1D
`define PMS_REG_PC2 5'h1F
`define PMS_BCTL_RST 16'h3100
`define PMS_OMO_RST 16'h0000
`define PMS_PC2_RST 16'h0000
`define PMS_OMO_BCOFF 9
`define PMS_PC2_MDIX 14
`define PMS_PC2_AUTOOFF 13
`define PMS_PC2_IRQPOL 9
`define PMS_PC2_TXOFF 3
`define PMS_PC2_RLB 2
`define PMS_BCTL_LLB 14
`define PMS_BCTL_SPD 13
`define PMS_BCTL_ANEN 12
`define PMS_BCTL_FDX 8
`define PMS_CDC_START 15
`define PMS_PRE_LEN 6'h20
`define PMS_OP_RD 2'h2
`define PMS_OP_WR 2'h1
`define PMS_CD_FAIL 2'h3
`define PMS_CD_TIME_US 100
`endif

// File: rtl/pms_ctrl.v
// Purpose: management serial slave with interrupt, crossover, loopback,
//   transmitter and cable diagnostic control registers
// Assumes: mgmt_clk and mgmt_data_in asynchronous, sampled by core_clk
// Notes: diagnostic analog engine is external: start pulse, done, result
`include "pms_defs.vh"
module pms_ctrl #(
  parameter CD_CYCLES = 2000
) (
  input wire core_clk,
  input wire rst,
  input wire mgmt_clk,
  input wire mgmt_data_in,
  output reg mgmt_data_out,
  output reg mgmt_data_oe,
  input wire [2:0] address_strap_pins,
  input wire broadcast_disable_strap,
  input wire [7:0] irq_events,
  input wire link_100_fdx,
  input wire partner_silenced,
  input wire cd_done,
  input wire [1:0] cd_result,
  input wire [8:0] cd_distance,
  output reg irq_out,
  output reg mdix_sel,
  output reg tx_disable,
  output reg local_loopback,
  output reg remote_loopback,
  output reg cd_start,
  output reg [15:0] bctl_out
);
  // Frame states
  localparam ST_PRE = 3'h0;
  localparam ST_HDR = 3'h1;
  localparam ST_TA = 3'h2;
  localparam ST_RD = 3'h3;
  localparam ST_WR = 3'h4;
  localparam ST_SKIP = 3'h5;

  reg clk_s1_reg, clk_s2_reg, clk_s3_reg;
  reg dat_s1_reg, dat_s2_reg;
  reg [2:0] st_reg;
  reg [5:0] cnt_reg;
  reg [13:0] hdr_reg;
  reg [15:0] sh_reg;
  reg hit_reg;
  reg [2:0] addr_reg;
  reg bcoff_strap_reg;
  reg strap_done_reg;
  reg [15:0] bctl_reg;
  reg [15:0] omo_reg;
  reg [15:0] pc2_reg;
  reg [7:0] ien_reg;
  reg [7:0] ist_reg;
  reg cd_run_reg;
  reg [1:0] cd_res_reg;
  reg [8:0] cd_dist_reg;
  reg [15:0] cd_tmo_reg;
  reg mdix_auto_reg;
  wire rise;
  wire fall;
  wire [4:0] ra;
  wire bcast_on;
  wire [15:0] rdata;
  wire wr_now;
  wire rd_ics;

  // Register read mux
  function [15:0] pms_read;
    input [4:0] a;
    input [15:0] b, o, p;
    input [7:0] en, st;
    input run;
    input [1:0] res;
    input [8:0] d;
    begin
      case (a)
        `PMS_REG_BCTL: pms_read = b;
        `PMS_REG_OMO: pms_read = o;
        `PMS_REG_ICS: pms_read = {en, st};
        `PMS_REG_CDC: pms_read = {run, res, 4'h0, d};
        `PMS_REG_PC2: pms_read = p;
        default: pms_read = 16'h0000;
      endcase
    end
  endfunction

  // Two-flop synchronisers plus edge history
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      dat_s1_reg <= 1'b1;
      dat_s2_reg <= 1'b1;
    end else begin
      clk_s1_reg <= mgmt_clk;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      dat_s1_reg <= mgmt_data_in;
      dat_s2_reg <= dat_s1_reg;
    end
  end

  assign rise = clk_s2_reg & ~clk_s3_reg;
  assign fall = ~clk_s2_reg & clk_s3_reg;
  assign ra = hdr_reg[4:0];
  assign bcast_on = ~bcoff_strap_reg & ~omo_reg[`PMS_OMO_BCOFF];
  assign rdata = pms_read(ra, bctl_reg, omo_reg, pc2_reg, ien_reg,
    ist_reg, cd_run_reg, cd_res_reg, cd_dist_reg);
  assign wr_now = rise && st_reg == ST_WR && cnt_reg == 6'h0F && hit_reg;
  // Opcode sits at 11..10 once all 13 header bits are shifted in
  assign rd_ics = rise && st_reg == ST_TA && cnt_reg == 6'h01 &&
    hdr_reg[11:10] == `PMS_OP_RD && hit_reg && ra == `PMS_REG_ICS;

  // Strap capture after reset release
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      addr_reg <= 3'h0;
      bcoff_strap_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      addr_reg <= address_strap_pins;
      bcoff_strap_reg <= broadcast_disable_strap;
    end
  end

  // Frame receive and transmit engine
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= ST_PRE;
      cnt_reg <= 6'h00;
      hdr_reg <= 14'h0000;
      sh_reg <= 16'h0000;
      hit_reg <= 1'b0;
      mgmt_data_out <= 1'b0;
      mgmt_data_oe <= 1'b0;
    end else begin
      if (rise) begin
        case (st_reg)
          ST_PRE: begin
            // Count ones, accept 01 start after full preamble
            if (dat_s2_reg) begin
              if (cnt_reg != 6'h3F)
                cnt_reg <= cnt_reg + 6'h01;
            end else if (cnt_reg >= `PMS_PRE_LEN) begin
              st_reg <= ST_HDR;
              cnt_reg <= 6'h00;
            end else
              cnt_reg <= 6'h00;
          end
          ST_HDR: begin
            // Start one bit, opcode, phy address, register address
            hdr_reg <= {hdr_reg[12:0], dat_s2_reg};
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == 6'h00 && !dat_s2_reg) begin
              st_reg <= ST_PRE;
              cnt_reg <= 6'h00;
            end else if (cnt_reg == 6'h0C) begin
              st_reg <= ST_TA;
              cnt_reg <= 6'h00;
              // Address 00AAA, own or broadcast 0; last bit not in yet
              hit_reg <= hdr_reg[8:7] == 2'h0 &&
                (hdr_reg[6:4] == addr_reg ||
                 (bcast_on && hdr_reg[6:4] == 3'h0));
            end
          end
          ST_TA: begin
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == 6'h01) begin
              cnt_reg <= 6'h00;
              sh_reg <= rdata;
              if (hdr_reg[11:10] == `PMS_OP_RD && hit_reg)
                st_reg <= ST_RD;
              else if (hdr_reg[11:10] == `PMS_OP_WR)
                st_reg <= ST_WR;
              else
                st_reg <= ST_SKIP;
            end
          end
          ST_RD: begin
            cnt_reg <= cnt_reg + 6'h01;
            sh_reg <= {sh_reg[14:0], 1'b0};
            if (cnt_reg == 6'h0F) begin
              st_reg <= ST_PRE;
              cnt_reg <= 6'h00;
            end
          end
          ST_WR: begin
            sh_reg <= {sh_reg[14:0], dat_s2_reg};
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == 6'h0F) begin
              st_reg <= ST_PRE;
              cnt_reg <= 6'h00;
            end
          end
          ST_SKIP: begin
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg == 6'h0F) begin
              st_reg <= ST_PRE;
              cnt_reg <= 6'h00;
            end
          end
          default: begin
            st_reg <= ST_PRE;
            cnt_reg <= 6'h00;
          end
        endcase
      end
      // Drive on falling edge: turnaround 0, then data MSB first
      if (fall) begin
        if (st_reg == ST_TA && cnt_reg == 6'h01 && hit_reg &&
            hdr_reg[11:10] == `PMS_OP_RD) begin
          mgmt_data_oe <= 1'b1;
          mgmt_data_out <= 1'b0;
        end else if (st_reg == ST_RD) begin
          mgmt_data_oe <= 1'b1;
          mgmt_data_out <= sh_reg[15];
        end else begin
          mgmt_data_oe <= 1'b0;
          mgmt_data_out <= 1'b0;
        end
      end
    end
  end

  // Control registers and write decode
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bctl_reg <= `PMS_BCTL_RST;
      omo_reg <= `PMS_OMO_RST;
      pc2_reg <= `PMS_PC2_RST;
      ien_reg <= 8'h00;
    end else if (wr_now) begin
      case (ra)
        `PMS_REG_BCTL: bctl_reg <= {sh_reg[14:0], dat_s2_reg};
        `PMS_REG_OMO: omo_reg <= {sh_reg[14:0], dat_s2_reg};
        `PMS_REG_ICS: ien_reg <= sh_reg[14:7];
        `PMS_REG_PC2: pc2_reg <= {sh_reg[14:0], dat_s2_reg};
        default: ien_reg <= ien_reg;
      endcase
    end
  end

  // Sticky status, new event wins over read clear
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      ist_reg <= 8'h00;
    else
      ist_reg <= (rd_ics ? 8'h00 : ist_reg) | irq_events;
  end

  // Cable diagnostic sequencer
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cd_run_reg <= 1'b0;
      cd_res_reg <= 2'h0;
      cd_dist_reg <= 9'h000;
      cd_tmo_reg <= 16'h0000;
      cd_start <= 1'b0;
    end else begin
      cd_start <= 1'b0;
      if (wr_now && ra == `PMS_REG_CDC && sh_reg[14] && !cd_run_reg) begin
        if (!partner_silenced) begin
          cd_res_reg <= `PMS_CD_FAIL;
          cd_dist_reg <= 9'h000;
        end else begin
          cd_run_reg <= 1'b1;
          cd_start <= 1'b1;
          cd_tmo_reg <= CD_CYCLES[15:0];
        end
      end else if (cd_run_reg) begin
        cd_tmo_reg <= cd_tmo_reg - 16'h0001;
        if (cd_done) begin
          cd_run_reg <= 1'b0;
          cd_res_reg <= cd_result;
          cd_dist_reg <= cd_distance;
        end else if (cd_tmo_reg == 16'h0000) begin
          cd_run_reg <= 1'b0;
          cd_res_reg <= `PMS_CD_FAIL;
        end
      end
    end
  end

  // Crossover, loopback, transmitter and interrupt outputs
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mdix_auto_reg <= 1'b0;
      mdix_sel <= 1'b0;
      tx_disable <= 1'b0;
      local_loopback <= 1'b0;
      remote_loopback <= 1'b0;
      irq_out <= 1'b1;
      bctl_out <= `PMS_BCTL_RST;
    end else begin
      // Auto mode alternates pairs on each event bit 0 pulse
      if (irq_events[0])
        mdix_auto_reg <= ~mdix_auto_reg;
      mdix_sel <= pc2_reg[`PMS_PC2_AUTOOFF] ?
        pc2_reg[`PMS_PC2_MDIX] : mdix_auto_reg;
      tx_disable <= pc2_reg[`PMS_PC2_TXOFF];
      local_loopback <= bctl_reg[`PMS_BCTL_LLB];
      remote_loopback <= pc2_reg[`PMS_PC2_RLB] & link_100_fdx;
      irq_out <= (|(ien_reg & ist_reg)) ~^
        pc2_reg[`PMS_PC2_IRQPOL];
      bctl_out <= bctl_reg;
    end
  end
endmodule

// File: dv/pms_ctrl_sva.sv
// Purpose: checker for the management serial slave ports
// Assumes: only the top module ports are visible
// Notes: attached with bind at the foot of this file
module pms_ctrl_sva (
  input wire core_clk,
  input wire rst,
  input wire mgmt_clk,
  input wire mgmt_data_out,
  input wire mgmt_data_oe,
  input wire link_100_fdx,
  input wire partner_silenced,
  input wire cd_start,
  input wire remote_loopback,
  input wire local_loopback,
  input wire [15:0] bctl_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mc_reg;
  logic [4:0] cnt_reg;
  wire rise = mgmt_clk & !mc_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Counts clock rises while the slave drives the line
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mc_reg <= 1'b0;
      cnt_reg <= 5'h00;
    end else begin
      mc_reg <= mgmt_clk;
      if (!mgmt_data_oe)
        cnt_reg <= 5'h00;
      else if (rise)
        cnt_reg <= cnt_reg + 5'h01;
    end
  end
  a_data_steady: assert property (
    mgmt_data_oe && $past(mgmt_data_oe) && mgmt_clk && $past(mgmt_clk)
    |-> $stable(mgmt_data_out)) else $error("data moved, clock high");
  a_drive_clk_low: assert property (
    $rose(mgmt_data_oe) |-> !mgmt_clk) else $error("drive began high");
  a_drive_span: assert property (
    $fell(mgmt_data_oe) |-> cnt_reg == 5'h11) else $error("drive span");
  a_ta_zero: assert property (
    mgmt_data_oe && rise && cnt_reg == 5'h00 |-> !mgmt_data_out)
    else $error("turnaround bit not zero");
  a_cd_pulse: assert property (
    cd_start |=> !cd_start) else $error("start pulse too long");
  a_cd_silence: assert property (
    !partner_silenced [*3] |-> !cd_start) else $error("start unsilenced");
  a_rlb_link: assert property (
    !link_100_fdx [*2] |-> !remote_loopback) else $error("remote no link");
  a_llb_bit: assert property (
    !bctl_out[14] [*2] |-> !local_loopback) else $error("local loop off");
  c_read: cover property ($fell(mgmt_data_oe));
  c_diag: cover property (cd_start);
  c_remote: cover property (remote_loopback);
endmodule
bind pms_ctrl pms_ctrl_sva pms_ctrl_sva_i (.*);

// File: dv/pms_mgmt_model.sv
// Purpose: station management controller model
// Assumes: pull-up on the data line, clock idles low between frames
// Notes: the bench calls the frame task
module pms_mgmt_model (
  output logic mgmt_clk,
  output wire mgmt_data_in,
  input wire mgmt_data_out,
  input wire mgmt_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'b0;
  logic val = 1'b1;
  // Released line floats to the pull-up level
  assign mgmt_data_in = mgmt_data_oe ? mgmt_data_out : (drv ? val : 1'b1);
  initial mgmt_clk = 1'b0;
  // One bit: data set while low, sampled at the rise, 2.5 MHz
  task automatic bit1(input logic d, input logic rel, output logic q);
    drv = !rel;
    val = d;
    #200 mgmt_clk = 1'b1;
    q = mgmt_data_in;
    #200 mgmt_clk = 1'b0;
  endtask
  // Whole frame; pre gives the preamble length
  task automatic frame(input int pre, input logic [1:0] op,
      input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd, output logic ta);
    logic [13:0] h;
    logic q;
    logic rdop;
    h = {2'b01, op, phy, ra};
    rdop = (op == 2'h2);
    #7;
    for (int i = 0; i < pre; i++)
      bit1(1'b1, 1'b0, q);
    for (int i = 13; i >= 0; i--)
      bit1(h[i], 1'b0, q);
    bit1(1'b1, rdop, q);
    bit1(1'b0, rdop, ta);
    for (int i = 15; i >= 0; i--) begin
      bit1(wd[i], rdop, q);
      rd[i] = q;
    end
    drv = 1'b0;
  endtask
endmodule

// File: dv/pms_ctrl_tb.sv
// Purpose: bench for the management serial slave
// Assumes: straps give address 5 with broadcast enabled
// Notes: frames run through the controller model
module pms_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic mgmt_clk, mgmt_data_out, mgmt_data_oe, irq_out, mdix_sel, ta;
  logic tx_disable, local_loopback, remote_loopback, cd_start;
  logic [15:0] bctl_out, rv;
  wire mgmt_data_in;
  logic [2:0] address_strap_pins = 3'h5;
  logic broadcast_disable_strap = 1'b0;
  logic [7:0] irq_events = 8'h00;
  logic link_100_fdx = 1'b0;
  logic partner_silenced = 1'b1;
  logic cd_done = 1'b0;
  logic [1:0] cd_result = 2'h0;
  logic [8:0] cd_distance = 9'h000;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int cd_cnt = 0;
  pms_ctrl pms_ctrl_i (.*);
  pms_mgmt_model pms_mgmt_model_i (.*);
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // Start pulses seen mid-cycle, away from launch edge, and hang guard
  always @(negedge core_clk) begin
    cyc++;
    if (cd_start === 1'b1)
      cd_cnt++;
    if (cyc == 30000) begin
      mismatches++;
      $display("MISMATCH at %0t: timeout", $time);
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int pre, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    logic t;
    @(negedge core_clk);
    pms_mgmt_model_i.frame(pre, 2'h1, phy, ra, d, x, t);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic rd(input logic [4:0] phy, input logic [4:0] ra);
    @(negedge core_clk);
    pms_mgmt_model_i.frame(32, 2'h2, phy, ra, 16'h0000, rv, ta);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic pulse(input logic [7:0] e);
    @(negedge core_clk);
    irq_events = e;
    @(negedge core_clk);
    irq_events = 8'h00;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    rd(5'h05, 5'h00);
    chk(rv, 16'h3100);
    chk(ta, 16'h0000);
    rd(5'h05, 5'h1F);
    chk(rv, 16'h0000);
    chk(irq_out, 16'h0001);
    pulse(8'h01);
    chk(mdix_sel, 16'h0001);
    $display("Test reset values done");
    wr(32, 5'h05, 5'h1F, 16'h6008);
    chk({mdix_sel, tx_disable}, 16'h0003);
    wr(32, 5'h03, 5'h1F, 16'h0000);
    wr(32, 5'h0D, 5'h1F, 16'h0000);
    wr(31, 5'h05, 5'h1F, 16'h0000);
    rd(5'h03, 5'h1F);
    chk(rv, 16'hFFFF);
    rd(5'h05, 5'h1F);
    chk(rv, 16'h6008);
    wr(32, 5'h00, 5'h1F, 16'h2008);
    chk(mdix_sel, 16'h0000);
    rd(5'h00, 5'h1F);
    chk(rv, 16'h2008);
    wr(32, 5'h00, 5'h16, 16'h0200);
    wr(32, 5'h00, 5'h1F, 16'h0000);
    rd(5'h05, 5'h1F);
    chk(rv, 16'h2008);
    $display("Test addressing done");
    wr(32, 5'h05, 5'h1B, 16'h0200);
    pulse(8'h06);
    chk(irq_out, 16'h0000);
    rd(5'h05, 5'h1B);
    chk(rv, 16'h0207);
    chk(irq_out, 16'h0001);
    rd(5'h05, 5'h1B);
    chk(rv, 16'h0200);
    wr(32, 5'h05, 5'h1F, 16'h0200);
    chk({irq_out, tx_disable}, 16'h0000);
    pulse(8'h08);
    chk(irq_out, 16'h0000);
    pulse(8'h02);
    chk(irq_out, 16'h0001);
    rd(5'h05, 5'h1B);
    chk(rv, 16'h020A);
    $display("Test interrupt done");
    wr(32, 5'h05, 5'h00, 16'h6100);
    chk(bctl_out, 16'h6100);
    chk(local_loopback, 16'h0001);
    wr(32, 5'h05, 5'h1F, 16'h0004);
    chk(remote_loopback, 16'h0000);
    link_100_fdx = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(remote_loopback, 16'h0001);
    $display("Test loopback done");
    wr(32, 5'h05, 5'h1F, 16'h2000);
    for (int r = 0; r < 3; r++) begin
      cd_result = r[1:0];
      cd_distance = {7'h48, r[1:0]};
      wr(32, 5'h05, 5'h1D, 16'h8000);
      rd(5'h05, 5'h1D);
      chk(rv[15], 16'h0001);
      @(negedge core_clk);
      cd_done = 1'b1;
      @(negedge core_clk);
      cd_done = 1'b0;
      rd(5'h05, 5'h1D);
      chk(rv, {1'b0, r[1:0], 4'h0, 7'h48, r[1:0]});
    end
    chk(16'(cd_cnt), 16'h0003);
    partner_silenced = 1'b0;
    wr(32, 5'h05, 5'h1D, 16'h8000);
    rd(5'h05, 5'h1D);
    chk(rv & 16'hE000, 16'h6000);
    chk(16'(cd_cnt), 16'h0003);
    $display("Test cable diagnostic done");
    test_done();
  end
endmodule
